// ==== include/rsc_pkg.sv ====
// Constants and types shared by the register state capture block.
// Assumes a 10 MHz single clock and an Avalon-MM register master.
package rsc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned CELL_BITS    = 64;
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned FRAME_WORDS  = 2;
  localparam int unsigned STREAM_WORDS = 4;
  localparam int unsigned PTR_W        = 2;
  localparam int unsigned COUNT_W      = 16;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CMD     = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RB_DATA = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RB_RST  = 5'h10;

  // ****************************************************************
  // Fields, codes and reset values
  // ****************************************************************
  localparam int unsigned       CTRL_SHOT_BIT  = 0;
  localparam logic [WORD_W-1:0] CMD_CAPTURE    = 32'h0000_000C;
  localparam logic [WORD_W-1:0] CMD_RESTORE    = 32'h0000_000A;
  localparam logic [WORD_W-1:0] PAD_WORD       = 32'h0000_0000;
  localparam logic [CELL_BITS-1:0] INIT_VALUE  = 64'h0000_0000_0000_0000;
  localparam logic [PTR_W-1:0]  PAD_END        = 2'h2;

  typedef enum logic [0:0]
  {
    RSC_SHOT_IDLE = 1'b0,
    RSC_SHOT_HELD = 1'b1
  } rsc_shot_t;

  typedef struct packed
  {
    rsc_shot_t shot;
  } rsc_prim_state_t;

  typedef struct packed
  {
    logic                 ack;
    logic [WORD_W-1:0]    rdata;
    logic [CELL_BITS-1:0] cells;
    logic [CELL_BITS-1:0] restore_value;
    logic                 single_shot;
    logic                 cmd_pending;
    logic                 sample;
    logic                 restore;
    logic [PTR_W-1:0]     rb_ptr;
    logic [COUNT_W-1:0]   cap_count;
  } rsc_state_t;

endpackage

// ==== logic/rsc_capture_primitive.sv ====
// User-facing capture primitive: request qualifier with single-shot option.
// Assumes the request is synchronous to clk_i.
`timescale 1ns/1ps
module rsc_capture_primitive
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic capture_request_i,
  input  wire logic single_shot_option_i,
  output logic      fire_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  rsc_pkg::rsc_prim_state_t state;
  rsc_pkg::rsc_prim_state_t next_state;

  // Held request fires each edge unless single shot blocks repeats
  assign fire_o = capture_request_i &&
                  (!single_shot_option_i || state.shot == rsc_pkg::RSC_SHOT_IDLE); // R07 R08

  always_comb
  begin
    next_state = state;
    unique case (state.shot)
      rsc_pkg::RSC_SHOT_IDLE:
      begin
        if (capture_request_i)
        begin
          next_state.shot = rsc_pkg::RSC_SHOT_HELD;
        end
      end
      rsc_pkg::RSC_SHOT_HELD:
      begin
        if (!capture_request_i)
        begin
          next_state.shot = rsc_pkg::RSC_SHOT_IDLE; // R08
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state.shot <= rsc_pkg::RSC_SHOT_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule // rsc_capture_primitive

// ==== logic/rsc_register_state_capture.sv ====
// Register state capture: samples live register state into initial-state
// cells and streams them out for readback over Avalon-MM.
// Assumes all inputs synchronous to clk_i (10 MHz) and one Avalon master.
//
// Function
// (R01) Capture uses the normal readback read sequence plus one prior sampling step.
// (R02) Asserted request samples all registers into cells on the next rising edge.
// (R03) Captured value overwrites the cell holding that register's initial state.
// (R04) Controller must not restore after capture, else captured values reload.
// (R05) Writing the capture command code performs the same full capture.
// (R06) Restore command reloads every register from its configuration cell.
// (R07) Request held high recaptures on every rising edge.
// (R08) Single-shot option captures only on the first edge of one assertion.
// (R09) Captured values are stored inverted; readers complement them.
// (R10) Reader locates captured bits by absolute or frame-relative bit offset.
// (R11) Readback stream starts with one pad frame and holds no command words.
// (R12) User logic drives the request synchronously to the capture clock.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rsc_register_state_capture
(
  input  wire logic                               clk_i,
  input  wire logic                               rst_b_i,
  input  wire logic [rsc_pkg::ADDR_W-1:0]         avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [rsc_pkg::WORD_W-1:0]         avs_writedata,
  output logic [rsc_pkg::WORD_W-1:0]              avs_readdata,
  output logic                                    avs_waitrequest,
  input  wire logic [rsc_pkg::CELL_BITS-1:0]      live_state_i,
  input  wire logic                               capture_request_i,
  output logic                                    global_sample_strobe_o,
  output logic                                    restore_strobe_o,
  output logic [rsc_pkg::CELL_BITS-1:0]           restore_value_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic hit
  (
    input logic [rsc_pkg::ADDR_W-1:0] addr,
    input logic [rsc_pkg::ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  function automatic logic [rsc_pkg::WORD_W-1:0] stream_word
  (
    input logic [rsc_pkg::PTR_W-1:0]     ptr,
    input logic [rsc_pkg::CELL_BITS-1:0] cells
  );
    // Pad frame first, then cell words in order, nothing else
    if (ptr < rsc_pkg::PAD_END)
    begin
      stream_word = rsc_pkg::PAD_WORD; // R11
    end
    else if (ptr == rsc_pkg::PAD_END)
    begin
      stream_word = cells[rsc_pkg::WORD_W-1:0];
    end
    else
    begin
      stream_word = cells[rsc_pkg::CELL_BITS-1:rsc_pkg::WORD_W];
    end
  endfunction

  // ****************************************************************
  // State and capture primitive
  // ****************************************************************
  rsc_pkg::rsc_state_t state;
  rsc_pkg::rsc_state_t next_state;
  logic                user_fire;
  logic                fire;
  logic                wr_acc;
  logic                rd_acc;
  logic [rsc_pkg::WORD_W-1:0] cur_word;

  rsc_capture_primitive u_prim
  (
    .clk_i                (clk_i),
    .rst_b_i              (rst_b_i),
    .capture_request_i    (capture_request_i),
    .single_shot_option_i (state.single_shot),
    .fire_o               (user_fire)
  );

  // Both sources drive the same global sample
  assign fire     = user_fire || state.cmd_pending; // R02 R05
  assign wr_acc   = avs_write && state.ack;
  assign rd_acc   = avs_read && state.ack;
  assign cur_word = stream_word(state.rb_ptr, state.cells);

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest        = (avs_read || avs_write) && !state.ack;
  assign avs_readdata           = state.rdata;
  assign global_sample_strobe_o = state.sample;
  assign restore_strobe_o       = state.restore;
  assign restore_value_o        = state.restore_value;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_state             = state;
    next_state.ack         = (avs_read || avs_write) && !state.ack;
    next_state.sample      = fire; // R02
    next_state.restore     = 1'b0;
    next_state.cmd_pending = 1'b0;

    if (fire)
    begin
      // Inverted sense, written over the initial-state cells
      next_state.cells     = ~live_state_i; // R03 R09 R07
      next_state.cap_count = state.cap_count + 16'h0001;
    end

    if (avs_read && !state.ack)
    begin
      if (hit(avs_address, rsc_pkg::OFS_CTRL))
      begin
        next_state.rdata = {31'h0000_0000, state.single_shot};
      end
      else if (hit(avs_address, rsc_pkg::OFS_STATUS))
      begin
        next_state.rdata = {16'h0000, state.cap_count};
      end
      else if (hit(avs_address, rsc_pkg::OFS_RB_DATA))
      begin
        next_state.rdata = cur_word; // R01 R11
      end
      else
      begin
        next_state.rdata = 32'h0000_0000;
      end
    end

    if (rd_acc && hit(avs_address, rsc_pkg::OFS_RB_DATA))
    begin
      // Stream wraps to the pad frame after the last word
      next_state.rb_ptr = state.rb_ptr + 2'h1; // R01
    end

    if (wr_acc)
    begin
      if (hit(avs_address, rsc_pkg::OFS_CMD))
      begin
        if (avs_writedata == rsc_pkg::CMD_CAPTURE)
        begin
          next_state.cmd_pending = 1'b1; // R05
        end
        else if (avs_writedata == rsc_pkg::CMD_RESTORE)
        begin
          // Reloads whatever the cells hold, captured or not
          next_state.restore       = 1'b1; // R06
          next_state.restore_value = ~state.cells; // R06 R09
        end
      end
      else if (hit(avs_address, rsc_pkg::OFS_CTRL))
      begin
        next_state.single_shot = avs_writedata[rsc_pkg::CTRL_SHOT_BIT]; // R08
      end
      else if (hit(avs_address, rsc_pkg::OFS_RB_RST))
      begin
        next_state.rb_ptr = 2'h0; // R11
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state.ack           <= 1'b0;
      state.rdata         <= 32'h0000_0000;
      state.cells         <= ~rsc_pkg::INIT_VALUE;
      state.restore_value <= rsc_pkg::INIT_VALUE;
      state.single_shot   <= 1'b0;
      state.cmd_pending   <= 1'b0;
      state.sample        <= 1'b0;
      state.restore       <= 1'b0;
      state.rb_ptr        <= 2'h0;
      state.cap_count     <= 16'h0000;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  capture_copy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R03
    fire |=> state.cells == ~$past(live_state_i))
    else $error("Cells not loaded with inverted live state");

  sample_strobe_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R02
    capture_request_i && !state.single_shot |=> global_sample_strobe_o)
    else $error("Request did not raise sample strobe");

  cmd_capture_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R05
    wr_acc && hit(avs_address, rsc_pkg::OFS_CMD) && avs_writedata == rsc_pkg::CMD_CAPTURE
    |-> ##2 global_sample_strobe_o)
    else $error("Capture command did not sample");

  restore_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R06
    wr_acc && hit(avs_address, rsc_pkg::OFS_CMD) && avs_writedata == rsc_pkg::CMD_RESTORE
    |=> restore_strobe_o && restore_value_o == ~$past(state.cells))
    else $error("Restore did not reload from cells");

  held_request_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R07
    (capture_request_i && !state.single_shot)[*3]
    |=> global_sample_strobe_o && $past(global_sample_strobe_o) && $past(global_sample_strobe_o, 2))
    else $error("Held request missed a recapture");

  single_shot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R08
    capture_request_i && $past(capture_request_i) && state.single_shot && $past(state.single_shot)
    |-> !user_fire)
    else $error("Single shot captured twice");

  pad_frame_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
    rd_acc && hit(avs_address, rsc_pkg::OFS_RB_DATA) && state.rb_ptr < rsc_pkg::PAD_END
    |-> avs_readdata == rsc_pkg::PAD_WORD)
    else $error("Pad frame word not zero");

  // Word order checked against the cells, not against the stream decoder
  stream_data_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R01
    rd_acc && hit(avs_address, rsc_pkg::OFS_RB_DATA) && state.rb_ptr == rsc_pkg::PAD_END
    |-> avs_readdata == $past(state.cells[rsc_pkg::WORD_W-1:0]))
    else $error("Readback low word mismatch");

  stream_high_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R01
    rd_acc && hit(avs_address, rsc_pkg::OFS_RB_DATA) && state.rb_ptr == 2'h3
    |-> avs_readdata == $past(state.cells[rsc_pkg::CELL_BITS-1:rsc_pkg::WORD_W]))
    else $error("Readback high word mismatch");

  user_capture_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    user_fire ##1 global_sample_strobe_o);

  cmd_restore_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    restore_strobe_o);

  full_stream_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_acc && hit(avs_address, rsc_pkg::OFS_RB_DATA) && state.rb_ptr == 2'h3);

endmodule // rsc_register_state_capture

// ==== verification/rsc_user_logic.sv ====
// Model of the user logic that drives the capture request and the live register state.
// Assumes one clock shared with the capture block; driven by the bench.
`timescale 1ns/1ps
module rsc_user_logic
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [3:0]  len_i,
  input  wire logic [63:0] base_i,
  output logic             capture_request_o,
  output logic [63:0]      live_state_o
);
  localparam logic [63:0] STEP = 64'h0101_0101_0101_0101;
  logic [3:0] dcnt;
  logic [3:0] hcnt;
  // Delay gives a slow partner; live value moves each held cycle
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dcnt              <= 4'h0;
      hcnt              <= 4'h0;
      capture_request_o <= 1'b0;
      live_state_o      <= 64'h0000_0000_0000_0000;
    end
    else if (start_i)
    begin
      dcnt              <= delay_i;
      hcnt              <= len_i;
      capture_request_o <= 1'b0;
      live_state_o      <= base_i;
    end
    else if (dcnt != 4'h0)
      dcnt <= dcnt - 4'h1;
    else if (hcnt != 4'h0)
    begin
      capture_request_o <= 1'b1;
      live_state_o      <= capture_request_o ? live_state_o + STEP : base_i;
      hcnt              <= hcnt - 4'h1;
    end
    else
      capture_request_o <= 1'b0;
  end
endmodule // rsc_user_logic

// ==== verification/tb_register_state_capture.sv ====
// Self-checking bench for the register state capture block.
// Assumes the package is compiled first and the user logic model beside it.
`timescale 1ns/1ps
module tb_register_state_capture;
  logic        clk_i, rst_b_i, avs_read, avs_write, avs_waitrequest, req, gss, rss, start;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [63:0] live, rval, c, base;
  logic [3:0]  delay, len;
  int          miscompares, total_checks, samples, cnt;
  localparam logic [63:0] STEP = 64'h0101_0101_0101_0101;

  rsc_register_state_capture DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .live_state_i(live), .capture_request_i(req),
    .global_sample_strobe_o(gss), .restore_strobe_o(rss), .restore_value_o(rval));
  rsc_user_logic u_user (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start), .delay_i(delay),
    .len_i(len), .base_i(base), .capture_request_o(req), .live_state_o(live));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Counted on the falling edge, away from the launch edge
  always @(negedge clk_i)
    if (gss === 1'b1) samples++;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(1'b1, 1'b0, "bus hang");
  endtask

  task automatic read_cells();
    bus(1'b1, rsc_pkg::OFS_RB_RST, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, rsc_pkg::OFS_RB_DATA, 32'h0000_0000);
      if (i < 2) chk(rd, rsc_pkg::PAD_WORD, "pad word");
      c = {rd, c[63:32]};
    end
  endtask

  task automatic go(input logic [3:0] dl, input logic [3:0] ln, input logic [63:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    start <= 1'b1;
    delay <= dl;
    len   <= ln;
    base  <= b;
    @(posedge clk_i);
    start <= 1'b0;
    if (ln != 4'h0)
    begin
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (req !== 1'b1 && n < 40);
      if (req !== 1'b1) chk(1'b1, 1'b0, "request timeout");
    end
  endtask

  task automatic status_is();
    bus(1'b0, rsc_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0], cnt, "capture count");
  endtask

  task automatic t_reset();
    read_cells();
    chk(c, ~rsc_pkg::INIT_VALUE, "cells after reset");
    bus(1'b0, rsc_pkg::OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "ctrl reset");
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    status_is();
    $display("test reset done");
  endtask

  // Restore issued only before any capture, so it reloads initial values
  task automatic t_restore();
    bus(1'b1, rsc_pkg::OFS_CMD, rsc_pkg::CMD_RESTORE);
    @(posedge clk_i);
    chk(rss, 1'b1, "restore strobe");
    chk(rval, rsc_pkg::INIT_VALUE, "restore value");
    @(posedge clk_i);
    chk(rss, 1'b0, "restore single pulse");
    bus(1'b1, rsc_pkg::OFS_CMD, 32'h0000_0005);
    repeat (3) @(posedge clk_i);
    chk(samples, 0, "bad command ignored");
    $display("test restore done");
  endtask

  task automatic t_pin();
    go(4'h0, 4'h1, 64'h1234_5678_9ABC_DEF0);
    @(posedge clk_i);
    chk(gss, 1'b1, "strobe after edge");
    @(posedge clk_i);
    chk(gss, 1'b0, "strobe single");
    cnt = cnt + 1;
    read_cells();
    chk(c, ~64'h1234_5678_9ABC_DEF0, "cells inverted");
    status_is();
    $display("test pin capture done");
  endtask

  task automatic t_held();
    int s0;
    s0 = samples;
    go(4'h2, 4'h3, 64'hA5A5_0000_5A5A_0000);
    repeat (6) @(posedge clk_i);
    chk(samples - s0, 3, "held request count");
    cnt = cnt + 3;
    read_cells();
    chk(c, ~(64'hA5A5_0000_5A5A_0000 + 2 * STEP), "last held value");
    status_is();
    $display("test held capture done");
  endtask

  task automatic t_shot();
    int s0;
    bus(1'b1, rsc_pkg::OFS_CTRL, 32'h0000_0001);
    bus(1'b0, rsc_pkg::OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "ctrl readback");
    s0 = samples;
    go(4'h0, 4'h3, 64'h0F0F_1111_2222_3333);
    go(4'h1, 4'h1, 64'h0000_FFFF_0000_4444);
    repeat (4) @(posedge clk_i);
    chk(samples - s0, 2, "one capture per assertion");
    cnt = cnt + 2;
    read_cells();
    chk(c, ~64'h0000_FFFF_0000_4444, "rearmed capture");
    bus(1'b1, rsc_pkg::OFS_CTRL, 32'h0000_0000);
    status_is();
    $display("test single shot done");
  endtask

  task automatic t_cmd();
    go(4'h0, 4'h0, 64'hCAFE_0000_BEEF_0001);
    bus(1'b1, rsc_pkg::OFS_CMD, rsc_pkg::CMD_CAPTURE);
    @(posedge clk_i);
    chk(gss, 1'b0, "command capture wait");
    @(posedge clk_i);
    chk(gss, 1'b1, "command capture strobe");
    cnt = cnt + 1;
    read_cells();
    chk(c, ~64'hCAFE_0000_BEEF_0001, "command capture cells");
    status_is();
    $display("test command capture done");
  endtask

  initial
  begin
    #300000;
    miscompares++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    {avs_read, avs_write, start, delay, len} = '0;
    avs_address   = 5'h00;
    avs_writedata = 32'h0000_0000;
    base          = 64'h0000_0000_0000_0000;
    rst_b_i       = 1'b0;
    cnt           = 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_restore();
    t_pin();
    t_held();
    t_shot();
    t_cmd();
    stop_test();
  end
endmodule // tb_register_state_capture
